// *** bench/limiter_model.sv ***
// transducer limiter level as seen at the sense pin
module limiter_model
   import sat_measure_pkg::*;
(
   input wire logic mclk,
   input wire logic [LEVEL_W-1:0] level_cmd,
   output logic [LEVEL_W-1:0] limiter_sense_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   always_ff @(posedge mclk) begin
      limiter_sense_pin <= level_cmd;
   end
endmodule

// *** bench/sat_measure_monitor.sv ***
// assertion checker on the register bus of the saturation measurement
module sat_measure_monitor
   import sat_measure_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [DATA_W-1:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [ADDR_W-1:0] ar_q;
   logic aw_w;
   logic rd_cnt;
   assign aw_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   assign rd_cnt = s_axi_rvalid && (ar_q == CAPTURE_OFFSET || ar_q == FILTER_OFFSET);
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) ar_q <= '0;
      else if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   write_hold_a: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response not held");
   read_hold_a: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   read_ready_a: assert property (s_axi_arready != s_axi_rvalid)
      else $error("arready not inverse of rvalid");
   write_answer_a: assert property (aw_w |-> ##[1:2] s_axi_bvalid)
      else $error("no write response");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("no read response");
   bad_addr_a: assert property (
      s_axi_rvalid && ar_q[1:0] != 2'h0 |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
      else $error("unaligned read not refused");
   count_width_a: assert property (rd_cnt |-> s_axi_rdata[31:8] == 24'h0)
      else $error("count wider than 8 bits");
   status_bits_a: assert property (
      s_axi_rvalid && ar_q == STATUS_OFFSET |-> s_axi_rdata[31:2] == 30'h0
      && !(s_axi_rdata[COMPLETE_BIT] && s_axi_rdata[BUSY_BIT]))
      else $error("status both complete and measuring");
   ctrl_bits_a: assert property (
      s_axi_rvalid && ar_q == CTRL_OFFSET |-> s_axi_rdata[31:3] == 29'h0)
      else $error("control read has stray bits");
   done_c: cover property (s_axi_rvalid && ar_q == STATUS_OFFSET && s_axi_rdata[0]);
   rerr_c: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
   werr_c: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule
bind saturation_time_measure sat_measure_monitor i_sat_measure_monitor (.mclk, .sys_rst,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .s_axi_rready);

// *** bench/tb.sv ***
// self-checking bench of the saturation measurement
module tb
   import sat_measure_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [1:0] sel; logic [7:0] lvl; logic done; logic [7:0] cap;} row_t;
   row_t rows [9] = '{'{2'h0, 8'h0F, 1'h1, 8'h00}, '{2'h0, 8'h10, 1'h0, 8'h01},
      '{2'h1, 8'h1F, 1'h1, 8'h00}, '{2'h1, 8'h20, 1'h0, 8'h01}, '{2'h2, 8'h3F, 1'h1, 8'h00},
      '{2'h2, 8'h40, 1'h0, 8'h01}, '{2'h3, 8'h5F, 1'h1, 8'h00}, '{2'h3, 8'h60, 1'h0, 8'h01},
      '{2'h3, 8'h80, 1'h1, 8'h00}};
   logic mclk, sys_rst = 1'h1, aw_v = 1'h0, w_v = 1'h0, b_r = 1'h0, ar_v = 1'h0, r_r = 1'h0;
   logic aw_rdy, w_rdy, b_v, ar_rdy, r_v;
   logic [1:0] b_resp, r_resp;
   logic [ADDR_W-1:0] aw_a = '0, ar_a = '0;
   logic [DATA_W-1:0] w_d = '0, r_d;
   logic [LEVEL_W-1:0] level_cmd = 8'h7F, pin;
   int num_errors = 0, checked = 0;
   limiter_model i_limiter_model (.mclk(mclk), .level_cmd(level_cmd), .limiter_sense_pin(pin));
   saturation_time_measure i_saturation_time_measure (.mclk(mclk), .sys_rst(sys_rst),
      .limiter_sense_pin(pin), .s_axi_awaddr(aw_a), .s_axi_awprot(3'h0), .s_axi_awvalid(aw_v),
      .s_axi_awready(aw_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v),
      .s_axi_wready(w_rdy), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
      .s_axi_araddr(ar_a), .s_axi_arprot(3'h0), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy),
      .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r));
   initial begin
      mclk = 1'h0;
      forever #50 mclk = ~mclk;
   end
   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, output logic [1:0] r);
      logic ta, tw, tb;
      int n;
      tb = 1'h0;
      n = 0;
      @(posedge mclk);
      aw_a <= a;
      w_d <= d;
      aw_v <= 1'h1;
      w_v <= 1'h1;
      b_r <= 1'h1;
      while (!tb && n < 100) begin
         @(negedge mclk);
         ta = aw_v && aw_rdy;
         tw = w_v && w_rdy;
         tb = b_v;
         r = b_resp;
         n++;
         @(posedge mclk);
         if (ta) aw_v <= 1'h0;
         if (tw) w_v <= 1'h0;
      end
      b_r <= 1'h0;
      check({31'h0, tb}, 32'h1);
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic [1:0] r);
      logic ta, tb;
      int n;
      tb = 1'h0;
      n = 0;
      @(posedge mclk);
      ar_a <= a;
      ar_v <= 1'h1;
      r_r <= 1'h1;
      while (!tb && n < 100) begin
         @(negedge mclk);
         ta = ar_v && ar_rdy;
         tb = r_v;
         d = r_d;
         r = r_resp;
         n++;
         @(posedge mclk);
         if (ta) ar_v <= 1'h0;
      end
      r_r <= 1'h0;
      check({31'h0, tb}, 32'h1);
   endtask
   task automatic put(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      logic [1:0] r;
      wr(a, d, r);
   endtask
   task automatic expect_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      logic [DATA_W-1:0] d;
      logic [1:0] r;
      rd(a, d, r);
      check(d, e);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      #(60000 * 100);
      num_errors++;
      report_and_stop();
   end
   initial begin
      logic [DATA_W-1:0] d;
      logic [1:0] r;
      cyc(4);
      sys_rst <= 1'h0;
      foreach (rows[i]) begin
         put(CTRL_OFFSET, 32'h0);
         put(FILTER_OFFSET, 32'h3);
         level_cmd <= rows[i].lvl;
         put(CTRL_OFFSET, {29'h0, rows[i].sel, 1'h1});
         cyc(200);
         expect_reg(STATUS_OFFSET, rows[i].done ? 32'h1 : 32'h2);
         expect_reg(CAPTURE_OFFSET, {24'h0, rows[i].cap});
      end
      $display("test threshold table done");
      put(CTRL_OFFSET, 32'h0);
      put(FILTER_OFFSET, 32'hA);
      level_cmd <= 8'h7F;
      put(CTRL_OFFSET, 32'h1);
      level_cmd <= 8'h00;
      cyc(60);
      level_cmd <= 8'h7F;
      cyc(10);
      level_cmd <= 8'h00;
      cyc(150);
      expect_reg(STATUS_OFFSET, 32'h2);
      cyc(100);
      expect_reg(STATUS_OFFSET, 32'h1);
      expect_reg(CAPTURE_OFFSET, 32'h1);
      put(CTRL_OFFSET, 32'h0);
      expect_reg(CAPTURE_OFFSET, 32'h0);
      expect_reg(STATUS_OFFSET, 32'h0);
      $display("test glitch and clear done");
      put(FILTER_OFFSET, 32'h0);
      level_cmd <= 8'h7F;
      put(CTRL_OFFSET, 32'h1);
      cyc(500);
      level_cmd <= 8'h00;
      cyc(20);
      expect_reg(CAPTURE_OFFSET, 32'h3);
      cyc(200);
      expect_reg(CAPTURE_OFFSET, 32'h3);
      put(CTRL_OFFSET, 32'h0);
      level_cmd <= 8'h7F;
      put(CTRL_OFFSET, 32'h7);
      expect_reg(CTRL_OFFSET, 32'h7);
      cyc(41200);
      expect_reg(CAPTURE_OFFSET, 32'hFF);
      expect_reg(STATUS_OFFSET, 32'h2);
      put(CAPTURE_OFFSET, 32'h55);
      expect_reg(CAPTURE_OFFSET, 32'hFF);
      put(FILTER_OFFSET, 32'hFFFF_FFFF);
      expect_reg(FILTER_OFFSET, 32'hFF);
      rd(4'h2, d, r);
      check({30'h0, r}, {30'h0, RESP_SLVERR});
      wr(4'h6, 32'h1, r);
      check({30'h0, r}, {30'h0, RESP_SLVERR});
      $display("test saturation and bus done");
      sys_rst <= 1'h1;
      cyc(4);
      sys_rst <= 1'h0;
      for (int k = 0; k < 4; k++) begin
         expect_reg(ADDR_W'(k * 4), 32'h0);
      end
      $display("test reset done");
      report_and_stop();
   end
endmodule

// *** core/dummy_unused_never.sv ***
// holds no logic; the block lives in the other core files

// *** core/sat_measure_pkg.sv ***
// constants, register map and types for the saturation time measurement
package sat_measure_pkg;

   // ************************************************
   // clock and timing
   // ************************************************
   localparam int CLK_PERIOD_NS = 100;
   localparam int FILTER_STEP_NS = 2000;
   localparam int SAT_STEP_NS = 16000;
   localparam int FILTER_STEP_CYCLES = (FILTER_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SAT_STEP_CYCLES = (SAT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FINE_W = $clog2(FILTER_STEP_CYCLES);
   localparam int COARSE_W = $clog2(SAT_STEP_CYCLES);

   // ************************************************
   // data widths
   // ************************************************
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int COUNT_W = 8;
   localparam int LEVEL_W = 8;
   localparam logic [COUNT_W-1:0] COUNT_MAX = 8'hFF;
   localparam logic [COUNT_W-1:0] COUNT_ZERO = 8'h00;

   // ************************************************
   // register map
   // ************************************************
   localparam logic [ADDR_W-1:0] CTRL_OFFSET = 4'h0;
   localparam logic [ADDR_W-1:0] FILTER_OFFSET = 4'h4;
   localparam logic [ADDR_W-1:0] CAPTURE_OFFSET = 4'h8;
   localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'hC;
   localparam int ENABLE_BIT = 0;
   localparam int SEL_LOW_BIT = 1;
   localparam int SEL_HIGH_BIT = 2;
   localparam int COMPLETE_BIT = 0;
   localparam int BUSY_BIT = 1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ************************************************
   // comparator thresholds, one per select code
   // ************************************************
   localparam logic [LEVEL_W-1:0] THRESH_0 = 8'h10;
   localparam logic [LEVEL_W-1:0] THRESH_1 = 8'h20;
   localparam logic [LEVEL_W-1:0] THRESH_2 = 8'h40;
   localparam logic [LEVEL_W-1:0] THRESH_3 = 8'h60;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_MEASURE = 2'h1,
      ST_DONE = 2'h3
   } meas_state_t;

endpackage

// *** core/saturation_time_measure.sv ***
// saturation time measurement with an axi4-lite register slave
// Contract
// - enabling starts the saturation timer from zero
// - only the positive part of the limiter level is compared
// - level below threshold starts the deglitch timer
// - deglitch time reached: capture timer value, set completion flag
// - no drop below threshold: flag stays 0, capture at most FF
// - disabling clears capture and completion flag
// - completion only after continuous below time; a rise restarts it
// - deglitch setting is 8 bits of 2 us each
// - capture is 8 bits of 16 us each
// - two-bit threshold select in a control register
module saturation_time_measure
   import sat_measure_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [LEVEL_W-1:0] limiter_sense_pin,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // ************************************************
   // address decode
   // ************************************************
   function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
      addr_ok = (a == CTRL_OFFSET) || (a == FILTER_OFFSET) ||
                (a == CAPTURE_OFFSET) || (a == STATUS_OFFSET);
   endfunction

   // ************************************************
   // state
   // ************************************************
   meas_state_t state_q;
   meas_state_t state_d;
   logic saturation_measure_enable_q;
   logic threshold_select_high_q;
   logic threshold_select_low_q;
   logic [COUNT_W-1:0] below_threshold_filter_time_q;
   logic [COUNT_W-1:0] saturation_duration_capture_q;
   logic saturation_measure_complete_q;
   logic [COUNT_W-1:0] sat_timer_q;
   logic [COUNT_W-1:0] filter_count_q;

   logic [ADDR_W-1:0] waddr_q;
   logic waddr_have_q;
   logic [DATA_W-1:0] wdata_q;
   logic [3:0] wstrb_q;
   logic wdata_have_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [DATA_W-1:0] rdata_q;
   logic [1:0] rresp_q;

   tick_if tk ();

   tick_divider u_ticks (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .tk(tk)
   );

   // ************************************************
   // axi handshakes and write decode
   // ************************************************
   assign s_axi_awready = ~waddr_have_q & ~bvalid_q;
   assign s_axi_wready = ~wdata_have_q & ~bvalid_q;
   assign s_axi_arready = ~rvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   wire aw_fire = s_axi_awvalid & s_axi_awready;
   wire w_fire = s_axi_wvalid & s_axi_wready;
   wire ar_fire = s_axi_arvalid & s_axi_arready;
   wire wr_do = waddr_have_q & wdata_have_q & ~bvalid_q;
   wire wr_ctrl = wr_do & (waddr_q == CTRL_OFFSET) & wstrb_q[0];
   wire wr_filter = wr_do & (waddr_q == FILTER_OFFSET) & wstrb_q[0];
   wire new_enable = wdata_q[ENABLE_BIT];
   wire start = wr_ctrl & new_enable & ~saturation_measure_enable_q;
   wire stop = wr_ctrl & ~new_enable & saturation_measure_enable_q;

   // ************************************************
   // comparator and threshold select
   // ************************************************
   wire [1:0] thresh_sel = {threshold_select_high_q, threshold_select_low_q};
   wire [LEVEL_W-1:0] threshold = (thresh_sel == 2'h0) ? THRESH_0 :
                                  (thresh_sel == 2'h1) ? THRESH_1 :
                                  (thresh_sel == 2'h2) ? THRESH_2 : THRESH_3;
   wire level_negative = limiter_sense_pin[LEVEL_W-1];
   wire [LEVEL_W-1:0] positive_level = level_negative ? '0 : limiter_sense_pin;
   wire below = positive_level < threshold;

   wire measuring = (state_q == ST_MEASURE);
   wire reached = measuring & below & (filter_count_q == below_threshold_filter_time_q);

   assign tk.restart = start;

   // ************************************************
   // measurement state machine
   // ************************************************
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (start) begin
               state_d = ST_MEASURE;
            end
         end
         ST_MEASURE: begin
            if (stop) begin
               state_d = ST_IDLE;
            end else if (reached) begin
               state_d = ST_DONE;
            end
         end
         ST_DONE: begin
            if (stop) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // ************************************************
   // saturation timer, saturating at all ones
   // ************************************************
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         sat_timer_q <= COUNT_ZERO;
      end else if (start || stop) begin
         sat_timer_q <= COUNT_ZERO;
      end else if (measuring && tk.tick_coarse && sat_timer_q != COUNT_MAX) begin
         sat_timer_q <= sat_timer_q + 1'b1;
      end
   end

   // ************************************************
   // deglitch timer, 2 us steps while below
   // ************************************************
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         filter_count_q <= COUNT_ZERO;
      end else if (start || !below || !measuring) begin
         filter_count_q <= COUNT_ZERO;
      end else if (tk.tick_fine && filter_count_q != COUNT_MAX) begin
         filter_count_q <= filter_count_q + 1'b1;
      end
   end

   // ************************************************
   // capture and completion
   // ************************************************
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         saturation_duration_capture_q <= COUNT_ZERO;
         saturation_measure_complete_q <= 1'b0;
      end else if (stop || start) begin
         saturation_duration_capture_q <= COUNT_ZERO;
         saturation_measure_complete_q <= 1'b0;
      end else if (reached) begin
         saturation_duration_capture_q <= sat_timer_q;
         saturation_measure_complete_q <= 1'b1;
      end else if (measuring) begin
         saturation_duration_capture_q <= sat_timer_q;
      end
   end

   // ************************************************
   // software registers
   // ************************************************
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         saturation_measure_enable_q <= 1'b0;
         threshold_select_high_q <= 1'b0;
         threshold_select_low_q <= 1'b0;
      end else if (wr_ctrl) begin
         saturation_measure_enable_q <= new_enable;
         threshold_select_high_q <= wdata_q[SEL_HIGH_BIT];
         threshold_select_low_q <= wdata_q[SEL_LOW_BIT];
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         below_threshold_filter_time_q <= COUNT_ZERO;
      end else if (wr_filter) begin
         below_threshold_filter_time_q <= wdata_q[COUNT_W-1:0];
      end
   end

   // ************************************************
   // axi write channel
   // ************************************************
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         waddr_q <= '0;
         waddr_have_q <= 1'b0;
         wdata_q <= '0;
         wstrb_q <= '0;
         wdata_have_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else begin
         if (aw_fire) begin
            waddr_q <= s_axi_awaddr;
            waddr_have_q <= 1'b1;
         end
         if (w_fire) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            wdata_have_q <= 1'b1;
         end
         if (wr_do) begin
            waddr_have_q <= 1'b0;
            wdata_have_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= addr_ok(waddr_q) ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // ************************************************
   // axi read channel
   // ************************************************
   logic [DATA_W-1:0] read_mux;

   always_comb begin
      read_mux = '0;
      case (s_axi_araddr)
         CTRL_OFFSET: begin
            read_mux[ENABLE_BIT] = saturation_measure_enable_q;
            read_mux[SEL_LOW_BIT] = threshold_select_low_q;
            read_mux[SEL_HIGH_BIT] = threshold_select_high_q;
         end
         FILTER_OFFSET: begin
            read_mux[COUNT_W-1:0] = below_threshold_filter_time_q;
         end
         CAPTURE_OFFSET: begin
            read_mux[COUNT_W-1:0] = saturation_duration_capture_q;
         end
         STATUS_OFFSET: begin
            read_mux[COMPLETE_BIT] = saturation_measure_complete_q;
            read_mux[BUSY_BIT] = measuring;
         end
         default: begin
            read_mux = '0;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
      end else if (ar_fire) begin
         rvalid_q <= 1'b1;
         rdata_q <= read_mux;
         rresp_q <= addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

endmodule

// *** core/tick_divider.sv ***
// divider making the 2 us and 16 us enable pulses
module tick_divider
   import sat_measure_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   tick_if.gen tk
);

   // ************************************************
   // counters
   // ************************************************
   logic [FINE_W-1:0] fine_q;
   logic [COARSE_W-1:0] coarse_q;
   wire fine_wrap = fine_q == FINE_W'(FILTER_STEP_CYCLES - 1);
   wire coarse_wrap = coarse_q == COARSE_W'(SAT_STEP_CYCLES - 1);

   assign tk.tick_fine = fine_wrap & ~tk.restart;
   assign tk.tick_coarse = coarse_wrap & ~tk.restart;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         fine_q <= '0;
      end else if (tk.restart || fine_wrap) begin
         fine_q <= '0;
      end else begin
         fine_q <= fine_q + 1'b1;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         coarse_q <= '0;
      end else if (tk.restart || coarse_wrap) begin
         coarse_q <= '0;
      end else begin
         coarse_q <= coarse_q + 1'b1;
      end
   end

endmodule

// *** core/tick_if.sv ***
// tick enables passed from the divider to the measurement logic
interface tick_if;
   logic restart;
   logic tick_fine;
   logic tick_coarse;
   modport gen (input restart, output tick_fine, output tick_coarse);
   modport user (output restart, input tick_fine, input tick_coarse);
endinterface
